/* File: hdl/udts_pkg.sv */
// Package with register map, field positions and reset values for the USB test and status block.
package udts_pkg;

  // ==========================================================================
  // Register map
  localparam logic [31:0] UDTS_ADDR_TEST   = 32'h49800018;
  localparam logic [31:0] UDTS_ADDR_STATUS = 32'h4980001C;

  // ==========================================================================
  // Test register fields
  localparam int UDTS_TR_SUPPLY  = 15;
  localparam int UDTS_TR_UNDERUN = 13;
  localparam int UDTS_TR_PIDERR  = 12;
  localparam int UDTS_TR_FORCE   = 4;
  localparam int UDTS_TR_PACKET  = 3;
  localparam int UDTS_TR_KSTATE  = 2;
  localparam int UDTS_TR_JSTATE  = 1;
  localparam int UDTS_TR_NAKRX   = 0;
  localparam logic [4:0] UDTS_TR_CTRL_RST = 5'h00;

  // ==========================================================================
  // Status register fields
  localparam int UDTS_SR_BYTEALIGN = 15;
  localparam int UDTS_SR_TIMEOUT   = 14;
  localparam int UDTS_SR_BITSTUFF  = 13;
  localparam int UDTS_SR_TOKCRC    = 12;
  localparam int UDTS_SR_DATCRC    = 11;
  localparam int UDTS_SR_OVERRUN   = 10;
  localparam int UDTS_SR_SUPLOSS   = 9;
  localparam int UDTS_SR_SUPSEEN   = 8;
  localparam int UDTS_SR_TOGGLE    = 7;
  localparam int UDTS_SR_DPLUS     = 6;
  localparam int UDTS_SR_DMINUS    = 5;
  localparam int UDTS_SR_HSPEED    = 4;
  localparam int UDTS_SR_SPDDONE   = 3;
  localparam int UDTS_SR_RESUME    = 2;
  localparam int UDTS_SR_SUSPEND   = 1;
  localparam int UDTS_SR_BUSRESET  = 0;
  localparam logic [15:0] UDTS_SR_STICKY_MASK = 16'hFF8F;
  localparam logic [15:0] UDTS_SR_RST         = 16'h0000;
  localparam logic [15:0] UDTS_TR_STICKY_RST  = 16'h0000;

  // ==========================================================================
  // Line drive modes toward the transceiver
  localparam logic [2:0] UDTS_LINE_NORMAL = 3'h0;
  localparam logic [2:0] UDTS_LINE_PACKET = 3'h1;
  localparam logic [2:0] UDTS_LINE_KSTATE = 3'h2;
  localparam logic [2:0] UDTS_LINE_JSTATE = 3'h3;
  localparam logic [2:0] UDTS_LINE_NAKRX  = 3'h4;

  // APB read data when idle or unmapped.
  localparam logic [31:0] UDTS_RDATA_RST = 32'h00000000;

endpackage

/* File: hdl/udts_core.sv */
// USB device test mode control and system status flag block with APB access.
`timescale 1ns/1ps

module udts_core (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        reset_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Control register enables taken from the neighbouring register
  input  wire logic        error_irq_enable_i,
  input  wire logic        supply_loss_irq_en_i,
  input  wire logic        supply_seen_irq_en_i,
  // Event pulses and the suspended and speed levels from the link logic, same clock
  input  wire logic        elastic_underrun_i,
  input  wire logic        pid_error_i,
  input  wire logic        byte_align_fault_i,
  input  wire logic        timeout_fault_i,
  input  wire logic        bitstuff_fault_i,
  input  wire logic        token_crc_fault_i,
  input  wire logic        data_crc_fault_i,
  input  wire logic        elastic_overrun_i,
  input  wire logic        toggle_mismatch_i,
  input  wire logic        speed_detect_done_i,
  input  wire logic        bus_reset_seen_i,
  input  wire logic        suspend_seen_i,
  input  wire logic        resume_seen_i,
  input  wire logic        suspended_i,
  input  wire logic        host_speed_hs_i,
  // Asynchronous pin levels
  input  wire logic        vbus_level_i,
  input  wire logic        plus_line_i,
  input  wire logic        minus_line_i,
  // Test controls toward the transceiver and packet logic
  output logic             test_mode_o,
  output logic [2:0]       line_mode_o,
  output logic             nak_all_in_o,
  output logic [4:0]       test_ctrl_o
);
  import udts_pkg::*;

  // ==========================================================================
  // Pin synchronisers
  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
    end else begin
      sync1_ff <= {vbus_level_i, plus_line_i, minus_line_i};
      sync2_ff <= sync1_ff;
    end
  end

  wire vbus_s  = sync2_ff[2];
  wire plus_s  = sync2_ff[1];
  wire minus_s = sync2_ff[0];

  // ==========================================================================
  // APB decode
  wire apb_access = psel_i & penable_i;
  wire apb_wr     = apb_access & pwrite_i;
  wire hit_test   = (paddr_i == UDTS_ADDR_TEST);
  wire hit_status = (paddr_i == UDTS_ADDR_STATUS);
  wire wr_test    = apb_wr & hit_test & pstrb_i[0];
  wire wr_test_hi = apb_wr & hit_test & pstrb_i[1];
  wire wr_status  = apb_wr & hit_status;
  wire [15:0] clr_mask = wr_status ? (pwdata_i[15:0] & {{8{pstrb_i[1]}}, {8{pstrb_i[0]}}}) : 16'h0000;

  // ==========================================================================
  // Test control bits
  logic [4:0] test_ctrl_ff;
  logic [4:0] nxt_test_ctrl;
  wire        force_now = test_ctrl_ff[UDTS_TR_FORCE];
  // A select is accepted only when force is already set and is also set in the same write.
  wire        force_new = pwdata_i[UDTS_TR_FORCE];

  always_comb begin
    nxt_test_ctrl = test_ctrl_ff;
    if (wr_test) begin
      nxt_test_ctrl[UDTS_TR_FORCE] = force_new;
      nxt_test_ctrl[3:0] = (force_now & force_new) ? pwdata_i[3:0] : 4'h0;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      test_ctrl_ff <= UDTS_TR_CTRL_RST;
    end else begin
      test_ctrl_ff <= nxt_test_ctrl;
    end
  end

  // ==========================================================================
  // Test mode outputs
  wire sel_ok = force_now & host_speed_hs_i;
  logic [2:0] nxt_line_mode;

  always_comb begin
    nxt_line_mode = UDTS_LINE_NORMAL;
    if (sel_ok & test_ctrl_ff[UDTS_TR_PACKET]) begin
      nxt_line_mode = UDTS_LINE_PACKET;
    end else if (sel_ok & test_ctrl_ff[UDTS_TR_KSTATE]) begin
      nxt_line_mode = UDTS_LINE_KSTATE;
    end else if (sel_ok & test_ctrl_ff[UDTS_TR_JSTATE]) begin
      nxt_line_mode = UDTS_LINE_JSTATE;
    end else if (sel_ok & test_ctrl_ff[UDTS_TR_NAKRX]) begin
      nxt_line_mode = UDTS_LINE_NAKRX;
    end
  end

  logic       test_mode_ff;
  logic [2:0] line_mode_ff;
  logic       nak_all_in_ff;
  logic [4:0] test_ctrl_out_ff;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      test_mode_ff     <= 1'b0;
      line_mode_ff     <= UDTS_LINE_NORMAL;
      nak_all_in_ff    <= 1'b0;
      test_ctrl_out_ff <= UDTS_TR_CTRL_RST;
    end else begin
      test_mode_ff     <= force_now;
      line_mode_ff     <= nxt_line_mode;
      nak_all_in_ff    <= (nxt_line_mode == UDTS_LINE_NAKRX);
      test_ctrl_out_ff <= test_ctrl_ff;
    end
  end

  assign test_mode_o  = test_mode_ff;
  assign line_mode_o  = line_mode_ff;
  assign nak_all_in_o = nak_all_in_ff;
  assign test_ctrl_o  = test_ctrl_out_ff;

  // ==========================================================================
  // Sticky flags in the test register
  logic [1:0] tr_flag_ff;
  wire  [1:0] tr_set;
  wire  [1:0] tr_clr;

  assign tr_set[1] = error_irq_enable_i & elastic_underrun_i;
  assign tr_set[0] = error_irq_enable_i & pid_error_i;
  assign tr_clr = wr_test_hi ? {pwdata_i[UDTS_TR_UNDERUN], pwdata_i[UDTS_TR_PIDERR]} : 2'h0;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      tr_flag_ff <= 2'h0;
    end else begin
      tr_flag_ff <= tr_set | (tr_flag_ff & ~tr_clr);
    end
  end

  // ==========================================================================
  // Sticky flags in the status register
  logic [15:0] sr_set;
  logic [15:0] sr_flag_ff;

  always_comb begin
    sr_set = 16'h0000;
    sr_set[UDTS_SR_BYTEALIGN] = error_irq_enable_i & byte_align_fault_i;
    sr_set[UDTS_SR_TIMEOUT]   = error_irq_enable_i & timeout_fault_i;
    sr_set[UDTS_SR_BITSTUFF]  = error_irq_enable_i & bitstuff_fault_i;
    sr_set[UDTS_SR_TOKCRC]    = error_irq_enable_i & token_crc_fault_i;
    sr_set[UDTS_SR_DATCRC]    = error_irq_enable_i & data_crc_fault_i;
    sr_set[UDTS_SR_OVERRUN]   = error_irq_enable_i & elastic_overrun_i;
    sr_set[UDTS_SR_SUPLOSS]   = supply_loss_irq_en_i & ~vbus_s;
    sr_set[UDTS_SR_SUPSEEN]   = supply_seen_irq_en_i & vbus_s;
    sr_set[UDTS_SR_TOGGLE]    = error_irq_enable_i & toggle_mismatch_i;
    sr_set[UDTS_SR_SPDDONE]   = speed_detect_done_i;
    sr_set[UDTS_SR_RESUME]    = suspended_i & resume_seen_i;
    sr_set[UDTS_SR_SUSPEND]   = suspend_seen_i;
    sr_set[UDTS_SR_BUSRESET]  = bus_reset_seen_i;
  end

  // Set wins over a same-cycle write-one clear.
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sr_flag_ff <= UDTS_SR_RST;
    end else begin
      sr_flag_ff <= (sr_set | (sr_flag_ff & ~clr_mask)) & UDTS_SR_STICKY_MASK;
    end
  end

  // ==========================================================================
  // Read data
  wire [31:0] tr_view = {16'h0000, vbus_s, 1'b0, tr_flag_ff, 7'h00, test_ctrl_ff};
  wire [31:0] sr_view = {16'h0000, sr_flag_ff[15:7], plus_s, minus_s, host_speed_hs_i,
                         sr_flag_ff[3:0]};
  wire [31:0] rd_mux  = hit_test ? tr_view : (hit_status ? sr_view : UDTS_RDATA_RST);

  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;

  // No wait state: pready rises in the first access cycle.
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      prdata_ff  <= UDTS_RDATA_RST;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= psel_i & ~penable_i;
      pslverr_ff <= psel_i & ~penable_i & ~(hit_test | hit_status);
      prdata_ff  <= (psel_i & ~penable_i & ~pwrite_i) ? rd_mux : UDTS_RDATA_RST;
    end
  end

  assign prdata_o  = prdata_ff;
  assign pready_o  = pready_ff;
  assign pslverr_o = pslverr_ff;

endmodule // udts_core

/* File: tb/udts_chk_sva.sv */
// Checker of the test line controls at the ports of the core.
`timescale 1ns/1ps
module udts_chk (
  // Watched ports
  input wire logic       core_clk_i,
  input wire logic       reset_i,
  input wire logic       host_speed_hs_i,
  input wire logic       test_mode_o,
  input wire logic [2:0] line_mode_o,
  input wire logic       nak_all_in_o,
  input wire logic [4:0] test_ctrl_o
);
  import udts_pkg::*;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);
  // ==========================================================================
  // Line drive modes
  a_mode_needs_force: assert property (line_mode_o != UDTS_LINE_NORMAL |-> test_mode_o)
    else $error("line mode active outside test mode");
  a_full_speed_idle: assert property (!$past(host_speed_hs_i) |-> line_mode_o == UDTS_LINE_NORMAL)
    else $error("line mode active at full speed");
  a_packet_wins: assert property (test_ctrl_o[4:3] == 2'h3 && $past(host_speed_hs_i)
    |-> line_mode_o == UDTS_LINE_PACKET) else $error("test packet not sent");
  a_k_level: assert property (test_ctrl_o[4:2] == 3'h5 && $past(host_speed_hs_i)
    |-> line_mode_o == UDTS_LINE_KSTATE) else $error("K level not held");
  a_j_level: assert property (test_ctrl_o[4:1] == 4'h9 && $past(host_speed_hs_i)
    |-> line_mode_o == UDTS_LINE_JSTATE) else $error("J level not held");
  a_nak_select: assert property (test_ctrl_o == 5'h11 && $past(host_speed_hs_i)
    |-> line_mode_o == UDTS_LINE_NAKRX) else $error("nak receive not held");
  a_nak_follows: assert property (nak_all_in_o == (line_mode_o == UDTS_LINE_NAKRX))
    else $error("nak flag disagrees with line mode");
  a_select_guard: assert property (test_ctrl_o[3:0] != 4'h0 |-> test_ctrl_o[4])
    else $error("select stored without test mode");
endmodule // udts_chk

/* File: tb/udts_link_model.sv */
// Model of the link side that reports bus events as single-cycle pulses.
`timescale 1ns/1ps
module udts_link_model (
  // Clock and command
  input  wire logic        core_clk_i,
  input  wire logic        fire_i,
  input  wire logic [3:0]  evt_i,
  // Event pulses
  output logic      [12:0] pulse_o
);
  // Each fault or host signalling event is one pulse.
  always_ff @(posedge core_clk_i) begin
    pulse_o <= fire_i ? (13'h0001 << evt_i) : 13'h0000;
  end
endmodule // udts_link_model

/* File: tb/test_usb_device_test_and_status.sv */
// Self-checking bench for the USB test mode and status block.
`timescale 1ns/1ps
module test_usb_device_test_and_status;
  import udts_pkg::*;
  logic        clk, rst, psel, pen, pwr, rdy, err, rerr, fire, error_irq_enable, sle, sse, sus, hs, vb, dp, dm, tm, nak;
  logic [31:0] paddr, pwdata, prdata, rd, a, x;
  logic [3:0]  evt;
  logic [12:0] ev;
  logic [2:0]  lm;
  logic [4:0]  tc;
  int          mismatches, compares, cyc;
  int          bitpos [13] = '{15, 14, 13, 12, 11, 10, 7, 3, 0, 1, 2, 13, 12};
  logic [2:0]  modes [4] = '{UDTS_LINE_NAKRX, UDTS_LINE_JSTATE, UDTS_LINE_KSTATE, UDTS_LINE_PACKET};
  udts_core dut_u (.core_clk_i(clk), .reset_i(rst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF), .prdata_o(prdata), .pready_o(rdy), .pslverr_o(err),
    .error_irq_enable_i(error_irq_enable), .supply_loss_irq_en_i(sle), .supply_seen_irq_en_i(sse),
    .byte_align_fault_i(ev[0]), .timeout_fault_i(ev[1]), .bitstuff_fault_i(ev[2]), .token_crc_fault_i(ev[3]),
    .data_crc_fault_i(ev[4]), .elastic_overrun_i(ev[5]), .toggle_mismatch_i(ev[6]), .speed_detect_done_i(ev[7]),
    .bus_reset_seen_i(ev[8]), .suspend_seen_i(ev[9]), .resume_seen_i(ev[10]), .elastic_underrun_i(ev[11]),
    .pid_error_i(ev[12]), .suspended_i(sus), .host_speed_hs_i(hs), .vbus_level_i(vb), .plus_line_i(dp),
    .minus_line_i(dm), .test_mode_o(tm), .line_mode_o(lm), .nak_all_in_o(nak), .test_ctrl_o(tc));
  udts_link_model link_u (.core_clk_i(clk), .fire_i(fire), .evt_i(evt), .pulse_o(ev));
  // ==========================================================================
  // Clock, timeout and tasks
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // The request stands until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [31:0] ad, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (rdy !== 1'b1);
    rd = prdata;
    rerr = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rdc(input logic [31:0] ad, input logic [31:0] e, input string m);
    apb(1'b0, ad, 32'h00000000);
    chk(rd, e, m);
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    {psel, pen, pwr, fire, error_irq_enable, sle, sse, sus, hs, vb, dp, dm} = '0;
    {paddr, pwdata, evt} = '0;
    rst = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rdc(UDTS_ADDR_TEST, 32'h0, "test reset");
    rdc(UDTS_ADDR_STATUS, 32'h0, "status reset");
    hs <= 1'b1;
    apb(1'b1, UDTS_ADDR_TEST, 32'h0000000F);
    rdc(UDTS_ADDR_TEST, 32'h0, "select without force");
    apb(1'b1, UDTS_ADDR_TEST, 32'h00000010);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, UDTS_ADDR_TEST, 32'h10 | (32'h1 << i));
      rdc(UDTS_ADDR_TEST, 32'h10 | (32'h1 << i), "select readback");
      @(negedge clk);
      chk(lm, modes[i], "line mode");
      chk(nak, i == 0, "nak all in");
      chk(tm, 1, "test mode");
    end
    apb(1'b1, UDTS_ADDR_TEST, 32'h0000001F);
    hs <= 1'b0;
    rdc(UDTS_ADDR_TEST, 32'h1F, "all selects");
    @(negedge clk);
    chk(lm, UDTS_LINE_NORMAL, "full speed");
    apb(1'b1, UDTS_ADDR_TEST, 32'h0);
    rdc(UDTS_ADDR_TEST, 32'h0, "test off");
    chk(tm, 0, "test mode off");
    sus <= 1'b1;
    for (int e = 0; e < 2; e++) begin
      error_irq_enable <= e[0];
      for (int k = 0; k < 13; k++) begin
        a = k > 10 ? UDTS_ADDR_TEST : UDTS_ADDR_STATUS;
        x = (e == 1 || (k > 6 && k < 11)) ? 32'h1 << bitpos[k] : 32'h0;
        @(posedge clk);
        fire <= 1'b1;
        evt <= k[3:0];
        @(posedge clk);
        fire <= 1'b0;
        rdc(a, x, "event flag");
        apb(1'b1, a, x);
        rdc(a, 32'h0, "flag cleared");
      end
    end
    vb <= 1'b1;
    sse <= 1'b1;
    repeat (4) @(posedge clk);
    rdc(UDTS_ADDR_STATUS, 32'h100, "supply seen");
    rdc(UDTS_ADDR_TEST, 32'h00008000, "supply level");
    sse <= 1'b0;
    vb <= 1'b0;
    sle <= 1'b1;
    repeat (4) @(posedge clk);
    rdc(UDTS_ADDR_STATUS, 32'h300, "supply loss");
    sle <= 1'b0;
    apb(1'b1, UDTS_ADDR_STATUS, 32'h300);
    rdc(UDTS_ADDR_STATUS, 32'h0, "supply cleared");
    dp <= 1'b1;
    hs <= 1'b1;
    repeat (4) @(posedge clk);
    rdc(UDTS_ADDR_STATUS, 32'h50, "plus line and speed");
    dp <= 1'b0;
    dm <= 1'b1;
    repeat (4) @(posedge clk);
    rdc(UDTS_ADDR_STATUS, 32'h30, "minus line and speed");
    rdc(UDTS_ADDR_STATUS + 32'h4, 32'h0, "unmapped data");
    chk(rerr, 1, "unmapped error");
    final_report();
  end
endmodule // test_usb_device_test_and_status
bind udts_core udts_chk chk_u (.core_clk_i, .reset_i, .host_speed_hs_i, .test_mode_o, .line_mode_o,
  .nak_all_in_o, .test_ctrl_o);
